/* File: pkg/hci_pkg.sv */
// constants, types and command decoding for the ascii host interpreter
// assumes a byte-wide serial receiver and transmitter on the same clock
package hci_pkg;
   localparam logic [7:0] ASC_CR = 8'h0D;
   localparam logic [7:0] ASC_LF = 8'h0A;
   localparam logic [7:0] ASC_SP = 8'h20;
   localparam logic [7:0] ASC_E = 8'h45;
   localparam logic [7:0] ASC_0 = 8'h30;
   localparam logic [7:0] ASC_R = 8'h52;
   localparam logic [7:0] CASE_FOLD = 8'hDF;
   localparam logic [3:0] ERR_CHAN = 4'h0;
   localparam logic [3:0] ERR_UNKNOWN = 4'h1;
   localparam logic [3:0] ERR_SYNTAX = 4'h2;
   localparam logic [3:0] ERR_EXPR = 4'h3;
   localparam logic [3:0] ERR_VALUE = 4'h4;
   localparam logic [3:0] ERR_ACTIVE = 4'h5;
   localparam logic [13:0] PARAM_MAX = 14'h270F;
   localparam logic [13:0] GAIN_RST = 14'h0000;
   localparam logic [13:0] INTEG_RST = 14'h0000;
   localparam logic [13:0] LEAD_RST = 14'h0000;
   localparam logic [3:0] MODE_INDEP = 4'h0;
   localparam logic [3:0] MODE_SLAVE = 4'h1;
   localparam logic [3:0] MODE_PRESS_COUPLED = 4'h3;
   localparam logic [3:0] MODE_PID = 4'h4;
   localparam logic [3:0] MODE_TEST = 4'h9;
   localparam logic [13:0] CHAN_MAX = 14'h0008;
   localparam logic [3:0] MENU_USER = 4'h0;
   // version figures are arbitrary
   localparam logic [15:0] VERSION_MAJOR = 16'h0001;
   localparam logic [15:0] VERSION_MINOR = 16'h0000;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [2:0] POW_TOP = 3'h4;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_LOCK, CMD_UNLOCK, CMD_DEFAULT, CMD_BOOT, CMD_ID,
      CMD_GAIN, CMD_INTEG, CMD_LEAD, CMD_MODE, CMD_STAT, CMD_ZERO
   } cmd_type;

   typedef enum logic [2:0] {
      RS_IDLE = 3'b000, RS_ERR = 3'b001, RS_CODE = 3'b011,
      RS_DIG = 3'b010, RS_SEP = 3'b110, RS_CR = 3'b111, RS_LF = 3'b101
   } reply_state_type;

   typedef struct packed {
      logic [7:0] unf_out;
      logic [7:0] ovf_out;
      logic [7:0] unf_in;
      logic [7:0] ovf_in;
      logic [7:0] trip_hi;
      logic [7:0] trip_lo;
      logic [7:0] on;
   } chan_flags_type;

   function automatic cmd_type cmd_decode(input logic [15:0] c);
      case (c)
         16'h4B44: cmd_decode = CMD_LOCK;
         16'h4B45: cmd_decode = CMD_UNLOCK;
         16'h4446: cmd_decode = CMD_DEFAULT;
         16'h5245: cmd_decode = CMD_BOOT;
         16'h4944: cmd_decode = CMD_ID;
         16'h474E: cmd_decode = CMD_GAIN;
         16'h4941: cmd_decode = CMD_INTEG;
         16'h4C44: cmd_decode = CMD_LEAD;
         16'h4D4F: cmd_decode = CMD_MODE;
         16'h5354: cmd_decode = CMD_STAT;
         16'h415A: cmd_decode = CMD_ZERO;
         default: cmd_decode = CMD_NONE;
      endcase
   endfunction

   function automatic logic [15:0] pow10(input logic [2:0] i);
      case (i)
         3'h0: pow10 = 16'h0001;
         3'h1: pow10 = 16'h000A;
         3'h2: pow10 = 16'h0064;
         3'h3: pow10 = 16'h03E8;
         default: pow10 = 16'h2710;
      endcase
   endfunction
endpackage

/* File: logic/host_cmd_interp.sv */
// ascii host command interpreter: line parser, executor, reply writer
// assumes rx/tx byte streams and panel signals share sys_clk
`timescale 1ns/1ps
module host_cmd_interp (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic rx_ready,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   input wire hci_pkg::chan_flags_type chan_flags,
   input wire logic [3:0] menu_sel,
   output logic panel_locked,
   output logic [3:0] display_menu,
   output logic boot_req,
   output logic zero_adj_req,
   output logic [2:0] zero_adj_chan,
   output logic [13:0] pid_gain,
   output logic [13:0] pid_integ,
   output logic [13:0] pid_lead
);
   // parser state
   logic [1:0] ccnt_q;
   logic cdone_q;
   logic [7:0] c0_q;
   logic [7:0] c1_q;
   logic [1:0] nf_q;
   logic [1:0] fi_q;
   logic infld_q;
   logic bad_q;
   logic [13:0] fv_q [3];
   logic fr_q [3];
   // executor and reply state
   hci_pkg::reply_state_type rs_q;
   logic [15:0] cur_q;
   logic [15:0] val2_q;
   logic [3:0] dig_q;
   logic [2:0] pi_q;
   logic started_q;
   logic vsel_q;
   logic [1:0] nv_q;
   logic [3:0] ecode_q;
   logic lasterr_q;
   logic boot_pend_q;
   logic [7:0] txd_q;
   logic txv_q;
   logic [3:0] saved_q;
   logic [3:0] disp_q;
   logic locked_q;
   logic zadj_q;
   logic [2:0] zch_q;
   logic boot_q;
   logic [13:0] gain_q;
   logic [13:0] integ_q;
   logic [13:0] lead_q;
   logic [3:0] mode_q [8];
   logic [2:0] master_q [8];
   logic [31:0] ctrl_q;
   logic [31:0] rdat_q;
   logic ack_q;

   logic acc;
   logic eol;
   logic is_dig;
   logic is_r;
   logic term;
   logic [17:0] nxt;
   logic [13:0] sat;
   hci_pkg::cmd_type cmd;
   logic pid_en;
   logic pid_cmd;
   logic chan_ok;
   logic [2:0] ch;
   logic [13:0] m;
   logic e_any;
   logic [3:0] e_code;
   logic [1:0] nv_d;
   logic [15:0] v1_d;
   logic [15:0] v2_d;
   logic ok;
   logic slot;
   logic ge;
   logic emitc;
   logic tx_load;
   logic [7:0] bd;

   assign pid_en = ctrl_q[0];
   assign rx_ready = (rs_q == hci_pkg::RS_IDLE);
   assign acc = rx_valid && rx_ready;
   assign eol = (rx_data == hci_pkg::ASC_CR) || (rx_data == hci_pkg::ASC_LF);
   assign is_dig = (rx_data >= hci_pkg::ASC_0) && (rx_data <= 8'h39);
   assign is_r = (rx_data & hci_pkg::CASE_FOLD) == hci_pkg::ASC_R;
   // blank lines (lone LF after CR) are dropped, not executed
   assign term = acc && eol && (ccnt_q != 2'h0);
   assign nxt = {4'h0, fv_q[fi_q]} * 18'h0000A + {14'h0, rx_data[3:0]};
   assign sat = (nxt > 18'h03FFF) ? 14'h3FFF : nxt[13:0];

   // tokenizer: fields saturate so huge numbers still read as too big
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ccnt_q <= 2'h0;
         cdone_q <= 1'b0;
         c0_q <= 8'h00;
         c1_q <= 8'h00;
         nf_q <= 2'h0;
         fi_q <= 2'h0;
         infld_q <= 1'b0;
         bad_q <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            fv_q[i] <= 14'h0000;
            fr_q[i] <= 1'b0;
         end
      end else if (acc) begin
         if (eol) begin
            ccnt_q <= 2'h0;
            cdone_q <= 1'b0;
            nf_q <= 2'h0;
            infld_q <= 1'b0;
            bad_q <= 1'b0;
         end else if (rx_data == hci_pkg::ASC_SP) begin
            infld_q <= 1'b0;
            if (ccnt_q != 2'h0) cdone_q <= 1'b1;
         end else if (!cdone_q) begin
            if (ccnt_q == 2'h0) c0_q <= rx_data & hci_pkg::CASE_FOLD;
            else c1_q <= rx_data & hci_pkg::CASE_FOLD;
            ccnt_q <= ccnt_q + 2'h1;
            if (ccnt_q == 2'h1) cdone_q <= 1'b1;
         end else if ((is_dig || is_r) && !infld_q) begin
            if (nf_q == 2'h3) begin
               bad_q <= 1'b1;
            end else begin
               fi_q <= nf_q;
               nf_q <= nf_q + 2'h1;
               infld_q <= 1'b1;
               fv_q[nf_q] <= is_dig ? {10'h000, rx_data[3:0]} : 14'h0000;
               fr_q[nf_q] <= !is_dig;
            end
         end else if (is_dig && !fr_q[fi_q]) begin
            fv_q[fi_q] <= sat;
         end else begin
            bad_q <= 1'b1;
         end
      end
   end

   assign cmd = hci_pkg::cmd_decode({c0_q, c1_q});
   assign pid_cmd = (cmd == hci_pkg::CMD_GAIN) ||
      (cmd == hci_pkg::CMD_INTEG) || (cmd == hci_pkg::CMD_LEAD);
   assign chan_ok = (nf_q != 2'h0) && !fr_q[0] && (fv_q[0] != 14'h0000) &&
      (fv_q[0] <= hci_pkg::CHAN_MAX);
   assign ch = fv_q[0][2:0] - 3'h1;
   assign m = fv_q[1];

   // error priority: short command, unknown, bad text, channel, range
   always_comb begin
      e_any = 1'b1;
      e_code = hci_pkg::ERR_CHAN;
      nv_d = 2'h0;
      v1_d = 16'h0000;
      v2_d = 16'h0000;
      if (ccnt_q == 2'h1) begin
         e_code = hci_pkg::ERR_SYNTAX;
      end else if (cmd == hci_pkg::CMD_NONE || (pid_cmd && !pid_en)) begin
         e_code = hci_pkg::ERR_UNKNOWN;
      end else if (bad_q) begin
         e_code = hci_pkg::ERR_EXPR;
      end else begin
         e_any = 1'b0;
         case (cmd)
            hci_pkg::CMD_STAT, hci_pkg::CMD_ZERO, hci_pkg::CMD_MODE: begin
               if (!chan_ok) begin
                  e_any = 1'b1;
                  e_code = hci_pkg::ERR_CHAN;
               end else if (cmd == hci_pkg::CMD_STAT) begin
                  nv_d = 2'h1;
                  v1_d = {6'h00, chan_flags.unf_out[ch],
                     chan_flags.ovf_out[ch], chan_flags.unf_in[ch],
                     chan_flags.ovf_in[ch], chan_flags.trip_hi[ch],
                     chan_flags.trip_lo[ch], 3'h0,
                     chan_flags.on[ch]};
               end else if (cmd == hci_pkg::CMD_ZERO) begin
                  if (chan_flags.on[ch]) begin
                     e_any = 1'b1;
                     e_code = hci_pkg::ERR_ACTIVE;
                  end
               end else if (nf_q < 2'h2) begin
                  e_any = 1'b1;
                  e_code = hci_pkg::ERR_EXPR;
               end else if (fr_q[1]) begin
                  nv_d = (mode_q[ch] == hci_pkg::MODE_SLAVE) ? 2'h2 : 2'h1;
                  v1_d = {12'h000, mode_q[ch]};
                  v2_d = {13'h0000, master_q[ch]} + 16'h0001;
               end else if (!(m <= 14'h0003 || m == 14'h0009 ||
                     (m == 14'h0004 && pid_en))) begin
                  e_any = 1'b1;
                  e_code = hci_pkg::ERR_VALUE;
               end else if (m == 14'h0001 && (nf_q != 2'h3 || fr_q[2] ||
                     fv_q[2] == 14'h0000 || fv_q[2] > hci_pkg::CHAN_MAX)) begin
                  e_any = 1'b1;
                  e_code = hci_pkg::ERR_VALUE;
               end
            end
            hci_pkg::CMD_GAIN, hci_pkg::CMD_INTEG, hci_pkg::CMD_LEAD: begin
               if (nf_q == 2'h0) begin
                  e_any = 1'b1;
                  e_code = hci_pkg::ERR_EXPR;
               end else if (fr_q[0]) begin
                  nv_d = 2'h1;
                  v1_d = {2'h0, (cmd == hci_pkg::CMD_GAIN) ? gain_q :
                     (cmd == hci_pkg::CMD_INTEG) ? integ_q : lead_q};
               end else if (fv_q[0] > hci_pkg::PARAM_MAX) begin
                  e_any = 1'b1;
                  e_code = hci_pkg::ERR_VALUE;
               end
            end
            hci_pkg::CMD_ID: begin
               nv_d = 2'h2;
               v1_d = hci_pkg::VERSION_MAJOR;
               v2_d = hci_pkg::VERSION_MINOR;
            end
            default: nv_d = 2'h0;
         endcase
      end
   end

   assign ok = term && !e_any;

   // stored parameters; restart reloads them like a power-up
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gain_q <= hci_pkg::GAIN_RST;
         integ_q <= hci_pkg::INTEG_RST;
         lead_q <= hci_pkg::LEAD_RST;
         for (int i = 0; i < 8; i++) begin
            mode_q[i] <= hci_pkg::MODE_INDEP;
            master_q[i] <= 3'h0;
         end
      end else if (boot_q || (ok && cmd == hci_pkg::CMD_DEFAULT)) begin
         gain_q <= hci_pkg::GAIN_RST;
         integ_q <= hci_pkg::INTEG_RST;
         lead_q <= hci_pkg::LEAD_RST;
         for (int i = 0; i < 8; i++) begin
            mode_q[i] <= hci_pkg::MODE_INDEP;
            master_q[i] <= 3'h0;
         end
      end else if (ok && !fr_q[0] && cmd == hci_pkg::CMD_GAIN) begin
         gain_q <= fv_q[0];
      end else if (ok && !fr_q[0] && cmd == hci_pkg::CMD_INTEG) begin
         integ_q <= fv_q[0];
      end else if (ok && !fr_q[0] && cmd == hci_pkg::CMD_LEAD) begin
         lead_q <= fv_q[0];
      end else if (ok && !fr_q[1] && cmd == hci_pkg::CMD_MODE) begin
         mode_q[ch] <= m[3:0];
         master_q[ch] <= fv_q[2][2:0] - 3'h1;
      end
   end

   // panel lock and menu forcing
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         locked_q <= 1'b0;
         saved_q <= hci_pkg::MENU_USER;
         disp_q <= hci_pkg::MENU_USER;
      end else if (ok && cmd == hci_pkg::CMD_LOCK) begin
         locked_q <= 1'b1;
         disp_q <= hci_pkg::MENU_USER;
         // a repeated lock must not save the forced user menu
         if (!locked_q) saved_q <= menu_sel;
      end else if (ok && cmd == hci_pkg::CMD_UNLOCK) begin
         locked_q <= 1'b0;
         disp_q <= locked_q ? saved_q : menu_sel;
      end else begin
         if (boot_q) locked_q <= 1'b0;
         disp_q <= (locked_q && !boot_q) ? hci_pkg::MENU_USER : menu_sel;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         zadj_q <= 1'b0;
         zch_q <= 3'h0;
      end else begin
         zadj_q <= ok && cmd == hci_pkg::CMD_ZERO;
         if (ok && cmd == hci_pkg::CMD_ZERO) zch_q <= ch;
      end
   end

   // restart fires only after the terminator has been handed out
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         boot_pend_q <= 1'b0;
         boot_q <= 1'b0;
      end else begin
         boot_q <= boot_pend_q && rs_q == hci_pkg::RS_LF && tx_load;
         if (ok && cmd == hci_pkg::CMD_BOOT) boot_pend_q <= 1'b1;
         else if (rs_q == hci_pkg::RS_LF && tx_load) boot_pend_q <= 1'b0;
      end
   end

   assign slot = !txv_q || tx_ready;
   assign ge = cur_q >= hci_pkg::pow10(pi_q);
   assign emitc = (dig_q != 4'h0) || started_q || (pi_q == 3'h0);

   always_comb begin
      tx_load = slot;
      bd = hci_pkg::ASC_LF;
      case (rs_q)
         hci_pkg::RS_ERR: bd = hci_pkg::ASC_E;
         hci_pkg::RS_CODE: bd = hci_pkg::ASC_0 + {4'h0, ecode_q};
         hci_pkg::RS_DIG: begin
            tx_load = slot && !ge && emitc;
            bd = hci_pkg::ASC_0 + {4'h0, dig_q};
         end
         hci_pkg::RS_SEP: bd = hci_pkg::ASC_SP;
         hci_pkg::RS_CR: bd = hci_pkg::ASC_CR;
         hci_pkg::RS_LF: bd = hci_pkg::ASC_LF;
         default: tx_load = 1'b0;
      endcase
   end

   // reply writer; decimal digits by repeated subtraction, no divider
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rs_q <= hci_pkg::RS_IDLE;
         cur_q <= 16'h0000;
         val2_q <= 16'h0000;
         dig_q <= 4'h0;
         pi_q <= 3'h0;
         started_q <= 1'b0;
         vsel_q <= 1'b0;
         nv_q <= 2'h0;
         ecode_q <= 4'h0;
         lasterr_q <= 1'b0;
      end else begin
         case (rs_q)
            hci_pkg::RS_IDLE: if (term) begin
               ecode_q <= e_code;
               lasterr_q <= e_any;
               nv_q <= nv_d;
               cur_q <= v1_d;
               val2_q <= v2_d;
               pi_q <= hci_pkg::POW_TOP;
               dig_q <= 4'h0;
               started_q <= 1'b0;
               vsel_q <= 1'b0;
               if (e_any) rs_q <= hci_pkg::RS_ERR;
               else if (nv_d != 2'h0) rs_q <= hci_pkg::RS_DIG;
               else rs_q <= hci_pkg::RS_CR;
            end
            hci_pkg::RS_ERR: if (tx_load) rs_q <= hci_pkg::RS_CODE;
            hci_pkg::RS_CODE: if (tx_load) rs_q <= hci_pkg::RS_CR;
            hci_pkg::RS_DIG: begin
               if (ge) begin
                  cur_q <= cur_q - hci_pkg::pow10(pi_q);
                  dig_q <= dig_q + 4'h1;
               end else if (!emitc || slot) begin
                  if (emitc) started_q <= 1'b1;
                  dig_q <= 4'h0;
                  if (pi_q != 3'h0) pi_q <= pi_q - 3'h1;
                  else if (!vsel_q && nv_q == 2'h2) rs_q <= hci_pkg::RS_SEP;
                  else rs_q <= hci_pkg::RS_CR;
               end
            end
            hci_pkg::RS_SEP: if (tx_load) begin
               rs_q <= hci_pkg::RS_DIG;
               cur_q <= val2_q;
               pi_q <= hci_pkg::POW_TOP;
               started_q <= 1'b0;
               vsel_q <= 1'b1;
            end
            hci_pkg::RS_CR: if (tx_load) rs_q <= hci_pkg::RS_LF;
            hci_pkg::RS_LF: if (tx_load) rs_q <= hci_pkg::RS_IDLE;
            default: rs_q <= hci_pkg::RS_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         txd_q <= 8'h00;
         txv_q <= 1'b0;
      end else if (tx_load) begin
         txd_q <= bd;
         txv_q <= 1'b1;
      end else if (tx_ready) begin
         txv_q <= 1'b0;
      end
   end

   // wishbone slave, one wait state, unmapped reads return zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
         ctrl_q <= hci_pkg::CTRL_RST;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q) begin
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == hci_pkg::REG_CTRL)
               ctrl_q <= {31'h0000_0000, wb_dat_i[0]};
            case (wb_adr_i)
               hci_pkg::REG_CTRL: rdat_q <= ctrl_q;
               hci_pkg::REG_STATUS: rdat_q <= {24'h00_0000, ecode_q, 1'b0,
                  lasterr_q, rs_q != hci_pkg::RS_IDLE, locked_q};
               default: rdat_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign tx_data = txd_q;
   assign tx_valid = txv_q;
   assign panel_locked = locked_q;
   assign display_menu = disp_q;
   assign boot_req = boot_q;
   assign zero_adj_req = zadj_q;
   assign zero_adj_chan = zch_q;
   assign pid_gain = gain_q;
   assign pid_integ = integ_q;
   assign pid_lead = lead_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   AST_LOCK: assert property (ok && cmd == hci_pkg::CMD_LOCK |=>
      panel_locked && display_menu == hci_pkg::MENU_USER)
      else $error("lock did not force user menu");
   AST_UNLOCK: assert property (ok && cmd == hci_pkg::CMD_UNLOCK &&
      locked_q |=> !panel_locked && display_menu == $past(saved_q))
      else $error("unlock did not restore menu");
   AST_DEFAULT: assert property (ok && cmd == hci_pkg::CMD_DEFAULT |=>
      pid_gain == hci_pkg::GAIN_RST && pid_lead == hci_pkg::LEAD_RST)
      else $error("defaults not loaded");
   AST_BOOT: assert property (boot_req |-> !$past(boot_req) &&
      $past(rs_q) == hci_pkg::RS_LF ##1 !panel_locked)
      else $error("restart pulse wrong");
   AST_NOPID: assert property (term && pid_cmd && !pid_en |=>
      ecode_q == hci_pkg::ERR_UNKNOWN && $stable(pid_gain))
      else $error("pid command taken without option");
   AST_RANGE: assert property (term && cmd == hci_pkg::CMD_GAIN &&
      pid_en && !bad_q && nf_q != 2'h0 &&
      !fr_q[0] && fv_q[0] > hci_pkg::PARAM_MAX |=> $stable(pid_gain)
      ##1 ecode_q == hci_pkg::ERR_VALUE)
      else $error("out of range gain accepted");
   AST_SHORT: assert property (term && ccnt_q == 2'h1 |=>
      rs_q == hci_pkg::RS_ERR && ecode_q == hci_pkg::ERR_SYNTAX)
      else $error("short command not code 2");
   AST_CRLF: assert property (tx_valid && tx_ready &&
      tx_data == hci_pkg::ASC_CR |=> tx_valid && tx_data == hci_pkg::ASC_LF)
      else $error("cr not followed by lf");
   AST_PARSE: assert property (acc && !eol |=>
      rs_q == hci_pkg::RS_IDLE && !tx_valid || $past(tx_valid))
      else $error("reply before terminator");
   AST_STATUS: assert property (ok && cmd == hci_pkg::CMD_STAT |=>
      cur_q[15] == 1'b0 && cur_q[0] == $past(chan_flags.on[ch]))
      else $error("status word wrong");

   COV_ERR: cover property (term && e_any ##[1:20] tx_data == hci_pkg::ASC_E);
   COV_TWO: cover property (rs_q == hci_pkg::RS_SEP ##[1:40]
      rs_q == hci_pkg::RS_LF);
   COV_LOCK: cover property (ok && cmd == hci_pkg::CMD_LOCK ##[1:200]
      ok && cmd == hci_pkg::CMD_UNLOCK);
endmodule

/* File: verification/host_link_model.sv */
// host end of the serial link: sends lines, gathers reply bytes
// assumes byte handshakes sampled at sys_clk rising edges
`timescale 1ns/1ps
module host_link_model (
   input wire logic sys_clk,
   input wire logic rx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic tx_ready
);
   logic [127:0] got = '0;
   bit slow = 0;
   initial begin
      rx_data = 8'hFF;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   // code, spaced fields, terminator
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         rx_data <= s[i];
         rx_valid <= 1'b1;
         do @(posedge sys_clk); while (rx_ready !== 1'b1);
      end
      rx_valid <= 1'b0;
      // released line must not keep the last byte
      rx_data <= ~s[s.len()-1];
   endtask
   // a slow host stalls every other cycle
   always @(posedge sys_clk) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready)
         got <= {got[119:0], tx_data};
   end
endmodule

/* File: verification/ascii_host_command_interpreter_tb_top.sv */
// self-checking bench for the ascii host command interpreter
// assumes the host link model drives the byte streams
`timescale 1ns/1ps
module ascii_host_command_interpreter_tb_top;
   logic sys_clk = 0, rstn = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
   logic [7:0] wb_adr_i = 8'h00, rx_data, tx_data;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic [3:0] wb_sel_i = 4'h1, menu_sel = 4'h5, display_menu;
   logic wb_ack_o, rx_ready, tx_valid, tx_ready, rx_valid;
   logic panel_locked, boot_req, zero_adj_req;
   logic [2:0] zero_adj_chan;
   logic [13:0] pid_gain, pid_integ, pid_lead;
   // ch1 low trip; ch2 on, high trip, in overflow, out underflow
   hci_pkg::chan_flags_type chan_flags =
      '{8'h02, 8'h00, 8'h00, 8'h02, 8'h02, 8'h01, 8'h02};
   int n_fail = 0, checks = 0, cyc = 0, n_boot = 0, n_zero = 0;
   localparam int N = 22;
   string cmd [N] = '{"GN 9999\r", "GN 10000\r", "GN 1.5\r", "GN R\r",
      "IA 250\r", "IA R\r", "LD 7\r", "LD R\r", "MO 3 1 5\r", "MO 3 R\r",
      "MO 9 0\r", "MO 5 7\r", "XX\r", "G\r", "ID\r", "ST 2\r", "ST 1\r",
      "AZ 2\r", "AZ 3\r", "MO 3 1\r", "ST\r", "GN 1 2 3 4\r"};
   logic [127:0] exp_q [N] = '{"\r\n", "E4\r\n", "E3\r\n", "9999\r\n",
      "\r\n", "250\r\n", "\r\n", "7\r\n", "\r\n", "1 5\r\n", "E0\r\n",
      "E4\r\n", "E1\r\n", "E2\r\n", "1 0\r\n", "609\r\n", "16\r\n",
      "E5\r\n", "\r\n", "E4\r\n", "E0\r\n", "E3\r\n"};
   host_cmd_interp u_host_cmd_interp (.*);
   host_link_model u_host_link_model (.*);
   initial forever #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      n_boot += (boot_req === 1'b1);
      n_zero += (zero_adj_req === 1'b1);
      cyc++;
      // whole run needs well under this many cycles
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [127:0] g, input logic [127:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic run(input string c, input logic [127:0] e);
      u_host_link_model.got <= '0;
      u_host_link_model.send(c);
      repeat (300) begin
         @(posedge sys_clk);
         if (u_host_link_model.got[7:0] === 8'h0A) break;
      end
      @(posedge sys_clk);
      chk(u_host_link_model.got, e);
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      chk(128'(rx_ready), 128'h1);
      wb(1'b0, hci_pkg::REG_CTRL, 32'h0);
      chk(128'(rd), 128'(hci_pkg::CTRL_RST));
      for (int i = 0; i < N; i++) begin
         u_host_link_model.slow <= i[0];
         run(cmd[i], exp_q[i]);
      end
      chk(128'(pid_gain), 128'd9999);
      chk(128'(zero_adj_chan), 128'h2);
      chk(128'(n_zero), 128'h1);
      foreach (cmd[m]) if (m inside {0, 2, 3, 4, 9}) begin
         run($sformatf("MO 5 %0d\r", m), "\r\n");
         run("MO 5 R\r", {8'h30 + 8'(m), 16'h0D0A});
      end
      run("KD\r", "\r\n");
      chk(128'({panel_locked, display_menu}), 128'h10);
      run("KE\r", "\r\n");
      chk(128'({panel_locked, display_menu}), 128'h05);
      wb(1'b1, hci_pkg::REG_CTRL, 32'h0);
      run("GN R\r", "E1\r\n");
      run("MO 5 4\r", "E4\r\n");
      wb(1'b0, hci_pkg::REG_STATUS, 32'h0);
      chk(128'(rd), 128'h44);
      wb(1'b1, hci_pkg::REG_CTRL, 32'h1);
      wb(1'b0, 8'h40, 32'h0);
      chk(128'(rd), 128'h0);
      run("DF\r", "\r\n");
      chk(128'({pid_gain, pid_integ, pid_lead}), 128'h0);
      run("GN 12\r", "\r\n");
      run("KD\r", "\r\n");
      run("RE\r", "\r\n");
      chk(128'(n_boot), 128'h1);
      chk(128'({panel_locked, pid_gain}), 128'h0);
      tally_and_finish();
   end
endmodule
